// ---- verilog/timer8_pkg.sv ----
// constants, register map and modes of the one-pulse / pwm timer
package timer8_pkg;

    // ========================================================================
    // register map (byte addresses on the apb)
    localparam logic [7:0] OFS_CTRL_A  = 8'h00;
    localparam logic [7:0] OFS_CTRL_B  = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_CAP1    = 8'h0c;
    localparam logic [7:0] OFS_CAP2    = 8'h10;
    localparam logic [7:0] OFS_CMP1    = 8'h14;
    localparam logic [7:0] OFS_CMP2    = 8'h18;
    localparam logic [7:0] OFS_COUNTER = 8'h1c;

    // ========================================================================
    // timer_control_a fields
    localparam int unsigned A_CAP_IRQ_EN  = 7;
    localparam int unsigned A_CMP_IRQ_EN  = 6;
    localparam int unsigned A_OVF_IRQ_EN  = 5;
    localparam int unsigned A_DURING_LVL  = 2;
    localparam int unsigned A_EDGE_SEL_1  = 1;
    localparam int unsigned A_AFTER_LVL   = 0;
    localparam logic [7:0]  CTRL_A_MASK   = 8'he7;

    // timer_control_b fields
    localparam int unsigned B_PIN_EN_1    = 7;
    localparam int unsigned B_PIN_EN_2    = 6;
    localparam int unsigned B_ONE_PULSE   = 5;
    localparam int unsigned B_PWM         = 4;
    localparam int unsigned B_CLK_SEL_HI  = 3;
    localparam int unsigned B_CLK_SEL_LO  = 2;
    localparam int unsigned B_EDGE_SEL_2  = 1;
    localparam logic [7:0]  CTRL_B_MASK   = 8'hfe;

    // timer_status_reg fields
    localparam int unsigned S_CAP_FLAG_1  = 7;
    localparam int unsigned S_CMP_FLAG_1  = 6;
    localparam int unsigned S_OVF_FLAG    = 5;
    localparam int unsigned S_CAP_FLAG_2  = 4;
    localparam int unsigned S_CMP_FLAG_2  = 3;

    localparam logic [7:0]  REG_RESET     = 8'h00;

    // ========================================================================
    // counter values
    localparam logic [7:0]  CNT_RESET     = 8'hfc;
    localparam logic [7:0]  CNT_LOAD      = 8'hfc;
    localparam logic [7:0]  CNT_MAX       = 8'hff;
    localparam logic [7:0]  CNT_STEP      = 8'h01;
    localparam logic [15:0] CAP_OPM_VALUE = 16'hfffd;

    // ========================================================================
    // prescaler
    localparam logic [1:0]  CLK_DIV4      = 2'b00;
    localparam logic [1:0]  CLK_DIV2      = 2'b01;
    localparam logic [1:0]  CLK_DIV8      = 2'b10;
    localparam logic [1:0]  CLK_SLOW      = 2'b11;
    localparam int unsigned DIV_2         = 2;
    localparam int unsigned DIV_4         = 4;
    localparam int unsigned DIV_8         = 8;
    localparam int unsigned DIV_SLOW      = 8000;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ONE_PULSE,
        MODE_PWM
    } mode_e;

endpackage : timer8_pkg

// ---- verilog/tick_if.sv ----
// timer tick carried from the prescaler to the counter logic
`timescale 1ns/1ps
interface tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface : tick_if

// ---- verilog/timer8_prescaler.sv ----
// prescaler that turns pclk into the timer tick
`timescale 1ns/1ps
module timer8_prescaler
    import timer8_pkg::*;
#(
    parameter int unsigned SLOW_DIV = DIV_SLOW
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] clock_select,
    input  wire logic       halt_mode,
    tick_if.src             tk
);
    localparam int unsigned DW = $clog2(SLOW_DIV);

    generate
        if (SLOW_DIV < DIV_8) begin : g_bad_div
            $error("timer8_prescaler: SLOW_DIV below 8 not supported");
        end
    endgenerate

    logic [DW-1:0] div_cnt_q;
    logic [DW-1:0] limit;
    logic [1:0]    sel_q;

    // ========================================================================
    // division ratio
    always_comb begin
        case (clock_select)
            CLK_DIV4: limit = DW'(DIV_4 - 1);
            CLK_DIV2: limit = DW'(DIV_2 - 1);
            CLK_DIV8: limit = DW'(DIV_8 - 1);
            default:  limit = DW'(SLOW_DIV - 1);
        endcase
    end

    // ========================================================================
    // divider; restarts on a ratio change so no short tick appears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= '0;
            sel_q     <= CLK_DIV4;
        end else begin
            sel_q <= clock_select;
            if (halt_mode) begin
                div_cnt_q <= div_cnt_q;
            end else if (sel_q != clock_select || div_cnt_q >= limit) begin
                div_cnt_q <= '0;
            end else begin
                div_cnt_q <= div_cnt_q + DW'(1);
            end
        end
    end

    // halt stops the tick, which freezes the counter
    assign tk.tick = !halt_mode && sel_q == clock_select
                     && div_cnt_q == limit;

endmodule : timer8_prescaler

// ---- verilog/timer8_pwm.sv ----
// 8-bit timer with one-pulse and pwm modes, apb register slave
// Function
// - one_pulse_select enables one-pulse mode
// - trigger edge loads counter, level, flag, capture
// - capture flag raises irq when enabled
// - flags clear by status read then access
// - compare 1 match ends the pulse
// - one-pulse never sets compare flag 1
// - pwm wins when both modes selected
// - one-pulse: input 1 no capture, input 2 captures
// - compare 2 still flags, drives no output
// - pwm compares double-buffered until period end
// - pwm matches drive after/during levels
// - pwm compare 2 match reloads counter
// - pwm never sets compare flags
// - pwm compare 2 match sets capture flag 1
// - pwm: input 1 disconnected, input 2 captures
// - levels 1/0 give high pulse between matches
// - compare output 1 needs pin enable
// - wait mode: timer runs, irq wakes device
// - halt freezes the timer registers
// - capture during halt fires at wake-up
// - clock_select picks the prescaler ratio
// - during_level routed to compare output 1 in special modes, output 2 in normal
`timescale 1ns/1ps
module timer8_pwm
    import timer8_pkg::*;
#(
    parameter int unsigned SLOW_DIV = DIV_SLOW
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_1,
    input  wire logic        capture_input_2,
    input  wire logic        wait_mode,
    input  wire logic        halt_mode,
    input  wire logic        irq_mask,
    output logic             compare_output_1,
    output logic             compare_output_1_oe,
    output logic             compare_output_2,
    output logic             compare_output_2_oe,
    output logic             timer_irq,
    output logic             wake_from_wait
);
    logic [7:0]  ctrl_a_q, ctrl_b_q, cmp1_q, cmp2_q, act1_q, act2_q, cnt_q;
    tick_if tk ();

    timer8_prescaler #(.SLOW_DIV(SLOW_DIV)) u_presc (
        .pclk         (pclk),
        .presetn      (presetn),
        .clock_select (ctrl_b_q[B_CLK_SEL_HI:B_CLK_SEL_LO]),
        .halt_mode    (halt_mode),
        .tk           (tk)
    );

    logic [15:0] cap1_q, cap2_q;
    logic [7:0]  status, rd_arm_q;
    logic [31:0] prdata_q;
    logic        capture_flag_1_q, compare_flag_1_q, tof_q, capture_flag_2_q, compare_flag_2_q;
    logic        in1_q, in2_q, halt_q, harm1_q, harm2_q, out1_q, out2_q;
    mode_e       mode;
    logic        setup, acc, wr, mapped;
    logic        edge1, edge2, running, halt_exit, trig1;
    logic        m1, m2, cap1_evt, cap2_evt;

    // ========================================================================
    // mode decode
    always_comb begin
        if (ctrl_b_q[B_PWM])
            mode = MODE_PWM;
        else if (ctrl_b_q[B_ONE_PULSE])
            mode = MODE_ONE_PULSE;
        else
            mode = MODE_NORMAL;
    end

    // ========================================================================
    // apb decode; zero wait states, read data registered in setup
    assign setup  = psel && !penable;
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign pready = 1'b1;
    assign mapped = paddr == OFS_CTRL_A || paddr == OFS_CTRL_B
                 || paddr == OFS_STATUS || paddr == OFS_CAP1
                 || paddr == OFS_CAP2   || paddr == OFS_CMP1
                 || paddr == OFS_CMP2   || paddr == OFS_COUNTER;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_q;

    assign status = {capture_flag_1_q, compare_flag_1_q, tof_q, capture_flag_2_q, compare_flag_2_q, 3'b000};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup && !pwrite) begin
            case (paddr)
                OFS_CTRL_A:  prdata_q <= {24'h0, ctrl_a_q};
                OFS_CTRL_B:  prdata_q <= {24'h0, ctrl_b_q};
                OFS_STATUS:  prdata_q <= {24'h0, status};
                OFS_CAP1:    prdata_q <= {16'h0, cap1_q};
                OFS_CAP2:    prdata_q <= {16'h0, cap2_q};
                OFS_CMP1:    prdata_q <= {24'h0, cmp1_q};
                OFS_CMP2:    prdata_q <= {24'h0, cmp2_q};
                OFS_COUNTER: prdata_q <= {24'h0, cnt_q};
                default:     prdata_q <= '0;
            endcase
        end
    end

    // ========================================================================
    // control and compare registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q <= REG_RESET;
            ctrl_b_q <= REG_RESET;
            cmp1_q   <= REG_RESET;
            cmp2_q   <= REG_RESET;
        end else if (wr) begin
            if (paddr == OFS_CTRL_A) ctrl_a_q <= pwdata[7:0] & CTRL_A_MASK;
            if (paddr == OFS_CTRL_B) ctrl_b_q <= pwdata[7:0] & CTRL_B_MASK;
            if (paddr == OFS_CMP1)   cmp1_q   <= pwdata[7:0];
            if (paddr == OFS_CMP2)   cmp2_q   <= pwdata[7:0];
        end
    end

    // active compare values; pwm takes new ones only at period end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act1_q <= REG_RESET;
            act2_q <= REG_RESET;
        end else if (mode != MODE_PWM || m2) begin
            act1_q <= cmp1_q;
            act2_q <= cmp2_q;
        end
    end

    // ========================================================================
    // input edges and halt tracking
    assign edge1 = ctrl_a_q[A_EDGE_SEL_1] ? (capture_input_1 && !in1_q)
                                          : (!capture_input_1 && in1_q);
    assign edge2 = ctrl_b_q[B_EDGE_SEL_2] ? (capture_input_2 && !in2_q)
                                          : (!capture_input_2 && in2_q);
    assign running   = !halt_mode;
    assign halt_exit = halt_q && !halt_mode;
    // input 1 is ignored entirely in pwm
    assign trig1 = running && edge1 && mode == MODE_ONE_PULSE;
    assign cap1_evt = mode == MODE_NORMAL
                      && ((running && edge1) || (halt_exit && harm1_q));
    assign cap2_evt = (running && edge2) || (halt_exit && harm2_q);
    assign m1 = tk.tick && cnt_q == act1_q;
    assign m2 = tk.tick && cnt_q == act2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in1_q   <= 1'b0;
            in2_q   <= 1'b0;
            halt_q  <= 1'b0;
            harm1_q <= 1'b0;
            harm2_q <= 1'b0;
        end else begin
            in1_q  <= capture_input_1;
            in2_q  <= capture_input_2;
            halt_q <= halt_mode;
            // an edge seen while halted is held until wake-up
            harm1_q <= halt_mode ? (harm1_q || edge1) : 1'b0;
            harm2_q <= halt_mode ? (harm2_q || edge2) : 1'b0;
        end
    end

    // ========================================================================
    // counter; runs unchanged in wait, frozen by the missing tick in halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= CNT_RESET;
        end else if (trig1) begin
            cnt_q <= CNT_LOAD;
        end else if (mode == MODE_PWM && m2) begin
            cnt_q <= CNT_LOAD;
        end else if (tk.tick) begin
            cnt_q <= cnt_q + CNT_STEP;
        end
    end

    // ========================================================================
    // capture registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap1_q <= '0;
            cap2_q <= '0;
        end else begin
            if (trig1)
                cap1_q <= CAP_OPM_VALUE;
            else if (cap1_evt)
                cap1_q <= {8'h00, cnt_q};
            if (cap2_evt)
                cap2_q <= {8'h00, cnt_q};
        end
    end

    // ========================================================================
    // flags: status read arms the seen bits, the matching access clears
    // them; a new event in the clearing cycle wins
    logic set_capture_flag_1, set_compare_flag_1, set_tof, set_capture_flag_2, set_compare_flag_2;
    logic clr_capture_flag_1, clr_compare_flag_1, clr_tof, clr_capture_flag_2, clr_compare_flag_2;

    assign set_capture_flag_1 = cap1_evt || trig1 || (mode == MODE_PWM && m2);
    assign set_compare_flag_1 = mode == MODE_NORMAL && m1;
    assign set_compare_flag_2 = mode != MODE_PWM && m2;
    assign set_capture_flag_2 = cap2_evt;
    assign set_tof  = tk.tick && cnt_q == CNT_MAX;

    assign clr_capture_flag_1 = acc && paddr == OFS_CAP1 && rd_arm_q[S_CAP_FLAG_1];
    assign clr_compare_flag_1 = acc && paddr == OFS_CMP1 && rd_arm_q[S_CMP_FLAG_1];
    assign clr_tof  = acc && paddr == OFS_COUNTER && rd_arm_q[S_OVF_FLAG];
    assign clr_capture_flag_2 = acc && paddr == OFS_CAP2 && rd_arm_q[S_CAP_FLAG_2];
    assign clr_compare_flag_2 = acc && paddr == OFS_CMP2 && rd_arm_q[S_CMP_FLAG_2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_arm_q <= '0;
        end else if (acc && !pwrite && paddr == OFS_STATUS) begin
            rd_arm_q <= prdata_q[7:0];
        end else begin
            rd_arm_q <= rd_arm_q & ~{clr_capture_flag_1, clr_compare_flag_1, clr_tof,
                                     clr_capture_flag_2, clr_compare_flag_2, 3'b000};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_flag_1_q <= 1'b0;
            compare_flag_1_q <= 1'b0;
            tof_q  <= 1'b0;
            capture_flag_2_q <= 1'b0;
            compare_flag_2_q <= 1'b0;
        end else begin
            capture_flag_1_q <= set_capture_flag_1 || (capture_flag_1_q && !clr_capture_flag_1);
            compare_flag_1_q <= set_compare_flag_1 || (compare_flag_1_q && !clr_compare_flag_1);
            tof_q  <= set_tof  || (tof_q  && !clr_tof);
            capture_flag_2_q <= set_capture_flag_2 || (capture_flag_2_q && !clr_capture_flag_2);
            compare_flag_2_q <= set_compare_flag_2 || (compare_flag_2_q && !clr_compare_flag_2);
        end
    end

    // ========================================================================
    // output waveforms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end else begin
            case (mode)
                MODE_ONE_PULSE: begin
                    if (trig1)
                        out1_q <= ctrl_a_q[A_DURING_LVL];
                    else if (m1)
                        out1_q <= ctrl_a_q[A_AFTER_LVL];
                end
                MODE_PWM: begin
                    if (m2)
                        out1_q <= ctrl_a_q[A_DURING_LVL];
                    else if (m1)
                        out1_q <= ctrl_a_q[A_AFTER_LVL];
                end
                default: begin
                    if (m1)
                        out1_q <= ctrl_a_q[A_AFTER_LVL];
                    if (m2)
                        out2_q <= ctrl_a_q[A_DURING_LVL];
                end
            endcase
        end
    end

    assign compare_output_1    = out1_q;
    assign compare_output_1_oe = ctrl_b_q[B_PIN_EN_1];
    assign compare_output_2    = out2_q;
    // output 2 loses its level bit to the pulse in the special modes
    assign compare_output_2_oe = ctrl_b_q[B_PIN_EN_2]
                                 && mode == MODE_NORMAL;

    // ========================================================================
    // interrupt request and wait wake-up
    assign timer_irq = !irq_mask
        && ((ctrl_a_q[A_CAP_IRQ_EN] && (capture_flag_1_q || capture_flag_2_q))
         || (ctrl_a_q[A_CMP_IRQ_EN] && (compare_flag_1_q || compare_flag_2_q))
         || (ctrl_a_q[A_OVF_IRQ_EN] && tof_q));
    assign wake_from_wait = wait_mode && timer_irq;

    // ========================================================================
    // assertions
    AST_OPM_LOAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig1 |=> cnt_q == CNT_LOAD && cap1_q == CAP_OPM_VALUE
                  && capture_flag_1_q && out1_q == $past(ctrl_a_q[A_DURING_LVL]))
        else $error("one-pulse trigger did not load timer");
    AST_OPM_END: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_ONE_PULSE && m1 && !trig1
        |=> out1_q == $past(ctrl_a_q[A_AFTER_LVL]))
        else $error("pulse not ended on compare 1 match");
    AST_NO_COMPARE_FLAG_1: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode != MODE_NORMAL && !compare_flag_1_q |=> !compare_flag_1_q)
        else $error("compare flag 1 set in special mode");
    AST_PWM_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_PWM && !m2 |=> $stable(act1_q) && $stable(act2_q))
        else $error("pwm compare changed mid period");
    AST_PWM_RELOAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_PWM && m2 |=> cnt_q == CNT_LOAD && capture_flag_1_q)
        else $error("pwm period end did not reload");
    AST_PWM_NO_COMPARE_FLAG_2: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_PWM && !compare_flag_2_q |=> !compare_flag_2_q)
        else $error("compare flag 2 set in pwm");
    AST_HALT_FREEZE: assert property (
        @(posedge pclk) disable iff (!presetn)
        halt_mode && !trig1
        |=> cnt_q == $past(cnt_q) && capture_flag_2_q == $past(capture_flag_2_q))
        else $error("timer moved during halt");
    AST_IRQ: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture_flag_1_q && ctrl_a_q[A_CAP_IRQ_EN] && !irq_mask |-> timer_irq)
        else $error("capture irq not raised");
    AST_CLR_TWO_STEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture_flag_1_q && !rd_arm_q[S_CAP_FLAG_1] |=> capture_flag_1_q)
        else $error("capture flag cleared without status read");
    AST_OPM_NO_CAP1: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_ONE_PULSE && !trig1 |=> $stable(cap1_q))
        else $error("capture 1 taken in one-pulse mode");
    AST_PWM_NO_CAP1: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == MODE_PWM |=> $stable(cap1_q))
        else $error("capture 1 taken in pwm mode");
    AST_OUT2_QUIET: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode != MODE_NORMAL |=> $stable(out2_q))
        else $error("compare output 2 moved in special mode");
    AST_HALT_CAPTURE: assert property (
        @(posedge pclk) disable iff (!presetn)
        halt_exit && harm2_q |=> capture_flag_2_q && cap2_q == {8'h00, $past(cnt_q)})
        else $error("armed capture not taken at halt exit");

endmodule : timer8_pwm

// ---- dv/ext_side.sv ----
// far-side model: trigger sources on the capture inputs, load on the pin
`timescale 1ns/1ps
module ext_side (
    input  wire logic pclk,
    input  wire logic fire_1,
    input  wire logic fire_2,
    input  wire logic drive,
    input  wire logic drive_oe,
    output logic      capture_input_1,
    output logic      capture_input_2,
    output wire logic pin
);
    // ==========
    // trigger sources change just after a clock edge; settled before reset ends
    always @(posedge pclk) begin
        capture_input_1 <= fire_1;
        capture_input_2 <= fire_2;
    end
    // pulled-down load: an undriven pin reads low, never the last level
    assign pin = drive_oe ? drive : 1'b0;
endmodule : ext_side

// ---- dv/tb.sv ----
// self-checking bench for the one-pulse / pwm timer
`timescale 1ns/1ps
module tb
    import timer8_pkg::*;
;
    localparam int unsigned SLOW = 8;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, held;
    logic        pready, pslverr, slv, cap_1, cap_2, pin;
    logic        wait_mode = 1'b0, halt_mode = 1'b0, irq_mask = 1'b0;
    logic        fire_1 = 1'b0, fire_2 = 1'b0;
    logic        cmp_1, cmp_1_oe, cmp_2, cmp_2_oe, timer_irq, wake;
    int          failures = 0, total_checks = 0, cycles = 0, n, hi, lo;
    logic [7:0]  rst_regs [4] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CMP1, OFS_CMP2};

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    timer8_pwm #(.SLOW_DIV(SLOW)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input_1(cap_1),
        .capture_input_2(cap_2), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .irq_mask(irq_mask),
        .compare_output_1(cmp_1), .compare_output_1_oe(cmp_1_oe),
        .compare_output_2(cmp_2), .compare_output_2_oe(cmp_2_oe),
        .timer_irq(timer_irq), .wake_from_wait(wake));

    ext_side i_ext (.pclk(pclk), .fire_1(fire_1), .fire_2(fire_2),
        .drive(cmp_1), .drive_oe(cmp_1_oe), .capture_input_1(cap_1),
        .capture_input_2(cap_2), .pin(pin));

    // ==========
    // helpers
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures = failures + 1;
            complete_run();
        end
    end

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // status is compared under a mask: free-running flags are left out
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
                         input string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
    endtask : rdchk

    // pin is sampled at rising edges, so widths come out in whole cycles
    task automatic wait_pin(input logic v, output int c);
        c = 0;
        while (pin !== v) begin
            @(posedge pclk);
            c++;
        end
    endtask : wait_pin

    function automatic int unsigned div(input int s);
        case (s)
            0: return DIV_4;
            1: return DIV_2;
            2: return DIV_8;
            default: return SLOW;
        endcase
    endfunction : div

    // ==========
    // tests
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_regs[i]) rdchk(rst_regs[i], '1, 32'h0, "reset");
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, slv);
        $display("test reset done");

        apb(OFS_CMP1, 1'b1, 32'h10);
        apb(OFS_CTRL_A, 1'b1, 32'h86);
        apb(OFS_CTRL_B, 1'b1, 32'he6);
        wait_mode <= 1'b1;
        fire_1 <= 1'b1;
        wait_pin(1'b1, n);
        chk("trigger delay", 32'h1, n <= 4);
        chk("irq", 32'h1, timer_irq);
        chk("wake", 32'h1, wake);
        wait_pin(1'b0, hi);
        chk("pulse width", 32'h1, hi >= 40 && hi <= 44);
        chk("out2 enable", 32'h0, cmp_2_oe);
        chk("out2 level", 32'h0, cmp_2);
        rdchk(OFS_CAP1, '1, 32'hfffd, "trigger capture");
        fire_2 <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(OFS_STATUS, 32'hd8, 32'h98, "opm flags");
        apb(OFS_CAP1, 1'b0, 32'h0);
        rdchk(OFS_STATUS, 32'h90, 32'h10, "clear 1");
        apb(OFS_CAP2, 1'b0, 32'h0);
        rdchk(OFS_STATUS, 32'h90, 32'h00, "clear 2");
        wait_mode <= 1'b0;
        $display("test one pulse done");

        apb(OFS_CMP1, 1'b1, 32'h00);
        apb(OFS_CMP2, 1'b1, 32'h08);
        apb(OFS_CTRL_A, 1'b1, 32'h81);
        for (int s = 3; s >= 0; s--) begin
            apb(OFS_CTRL_B, 1'b1, 32'hf2 | (s << 2));
            wait_pin(1'b0, n);
            wait_pin(1'b1, n);
            wait_pin(1'b0, hi);
            wait_pin(1'b1, lo);
            chk("pwm period", 13 * div(s), hi + lo);
            chk("pwm high", 8 * div(s), hi);
            chk("pwm out2 enable", 32'h0, cmp_2_oe);
        end
        wait_pin(1'b0, n);
        apb(OFS_CMP1, 1'b1, 32'h04);
        wait_pin(1'b1, n);
        wait_pin(1'b0, hi);
        chk("buffered high", 32, hi);
        wait_pin(1'b1, n);
        wait_pin(1'b0, hi);
        chk("new high", 16, hi);
        apb(OFS_STATUS, 1'b0, 32'h0);
        apb(OFS_CMP2, 1'b1, 32'h08);
        rdchk(OFS_STATUS, 32'hc8, 32'h80, "pwm flags");
        chk("pwm irq", 32'h1, timer_irq);
        irq_mask <= 1'b1;
        @(posedge pclk);
        chk("masked irq", 32'h0, timer_irq);
        irq_mask <= 1'b0;
        $display("test pwm done");

        apb(OFS_CTRL_B, 1'b1, 32'h06);
        fire_2 <= 1'b0;
        halt_mode <= 1'b1;
        apb(OFS_COUNTER, 1'b0, 32'h0);
        held = rd;
        fire_2 <= 1'b1;
        repeat (20) @(posedge pclk);
        rdchk(OFS_COUNTER, '1, held, "halt count");
        rdchk(OFS_STATUS, 32'h10, 32'h00, "halt armed");
        halt_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(OFS_STATUS, 32'h10, 32'h10, "wake flag");
        rdchk(OFS_CAP2, '1, held, "wake capture");
        $display("test halt done");
        complete_run();
    end
endmodule : tb
